// file: srs_defines.svh
/*
  Offsets, field positions, masks and reset values of the serial pin
  route selector. Assumes a plain register port with byte addresses.
*/
// Contract
// [RULE1] Clock field: 00 input alt0 no output; 01/10/11 both ways alt0/1/2.
// [RULE2] Data-out: 00 input alt0 no output; 01/10/11 both ways alt0/1/2.
// [RULE3] Data-in field: 00 and 01 alt0, 10 alt1, 11 alt2.
// [RULE4] Reset clears all fields: no pin driven, inputs from alt0.
// [RULE5] Reads return stored field values, without side effect.
// [RULE6] Reserved bit groups always read as zero.
// [RULE7] Software writes zeros into reserved bit groups.
// [RULE8] Deep standby reset keeps route contents; other resets clear them.
// [RULE9] Ch0 register: clock 9:8, data-out 7:6, data-in 5:4, 3:0 reserved.
// [RULE10] Ch4-7 reg: 31:28 reserved; ch7 clock 27:26, out 25:24, in 23:22.
// [RULE11] Ch6 clock 21:20, data-out 19:18, data-in 17:16.
// [RULE12] Ch5 clock 15:14 uses the common clock encoding.
// [RULE13] Second register holds only channels 4 to 7.
// [RULE14] Ch5 data-out 13:12, data-in 11:10; ch4 clock 9:8.
// [RULE15] Ch4 data-out 7:6, data-in 5:4, clear-to-send 3:2.
// [RULE16] Clear-to-send: 00 and 01 alt0, 10 alt1, 11 alt2.
// [RULE17] Request-to-send 1:0: 00 no output; 01/10/11 drive alt0/1/2.
// [RULE18] New field acts after the write, other channels undisturbed.
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH

`define SRS_OFF_CH0_ROUTE 8'h00
`define SRS_OFF_CH47_ROUTE 8'h04

`define SRS_CH0_ROUTE_RST 32'h00000000
`define SRS_CH47_ROUTE_RST 32'h00000000
`define SRS_CH0_ROUTE_MASK 32'h000003f0
`define SRS_CH47_ROUTE_MASK 32'h0fffffff

// each channel group is clock, data-out, data-in from high to low
`define SRS_GRP_W 6
`define SRS_CH0_GRP_LSB 4
`define SRS_CH4_GRP_LSB 4
`define SRS_CTS4_LSB 2
`define SRS_RTS4_LSB 0

`endif

// file: srs_pkg.sv
/*
  Types and code helpers of the serial pin route selector.
  Assumes nothing of its surroundings.
*/
package srs_pkg;

  typedef enum logic [1:0] {
    SRS_RT_IDLE = 2'b00,
    SRS_RT_ALT0 = 2'b01,
    SRS_RT_ALT1 = 2'b10,
    SRS_RT_ALT2 = 2'b11
  } srs_route_t;

  typedef struct packed {
    srs_route_t sck;
    srs_route_t serial_data_out_pin;
    srs_route_t serial_data_in_pin;
  } srs_ch_route_t;

  // index of the pin location feeding the channel input
  function automatic logic [1:0] srs_in_alt(input srs_route_t c);
    unique case (c)
      SRS_RT_ALT1: srs_in_alt = 2'h1;
      SRS_RT_ALT2: srs_in_alt = 2'h2;
      default: srs_in_alt = 2'h0;
    endcase
  endfunction : srs_in_alt

  // one-hot of the pin location driven, zero when idle
  function automatic logic [2:0] srs_out_alt(input srs_route_t c);
    unique case (c)
      SRS_RT_ALT0: srs_out_alt = 3'h1;
      SRS_RT_ALT1: srs_out_alt = 3'h2;
      SRS_RT_ALT2: srs_out_alt = 3'h4;
      default: srs_out_alt = 3'h0;
    endcase
  endfunction : srs_out_alt

endpackage : srs_pkg

// file: srs_chan_route.sv
/*
  One serial channel's pin router: clock, data-out, data-in.
  Assumes a synchronised reset and pins from outside the clock domain.
*/
`timescale 1ns/1ns
module srs_chan_route import srs_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic clr_in,
  input wire srs_ch_route_t route_in,
  input wire logic [2:0] sck_pin_in,
  output logic [2:0] sck_pin_out,
  output logic [2:0] sck_pin_oe_out,
  input wire logic [2:0] sot_pin_in,
  output logic [2:0] sot_pin_out,
  output logic [2:0] sot_pin_oe_out,
  input wire logic [2:0] sin_pin_in,
  input wire logic ch_sck_drv_in,
  input wire logic ch_sot_drv_in,
  output logic ch_sck_rx_out,
  output logic ch_sot_rx_out,
  output logic ch_sin_rx_out
);

  logic [8:0] meta_q;
  logic [8:0] sync_q;
  logic [2:0] sck_pin_d, sck_oe_d, sot_pin_d, sot_oe_d;
  logic sck_rx_d, sot_rx_d, sin_rx_d;
  logic [2:0] sck_s, sot_s, sin_s;

  assign sck_s = sync_q[2:0];
  assign sot_s = sync_q[5:3];
  assign sin_s = sync_q[8:6];

  always_comb begin
    sck_oe_d = srs_out_alt(route_in.sck); // [RULE1]
    sot_oe_d = srs_out_alt(route_in.serial_data_out_pin); // [RULE2]
    sck_pin_d = {3{ch_sck_drv_in}};
    sot_pin_d = {3{ch_sot_drv_in}};
    sck_rx_d = sck_s[srs_in_alt(route_in.sck)]; // [RULE1]
    sot_rx_d = sot_s[srs_in_alt(route_in.serial_data_out_pin)]; // [RULE2]
    sin_rx_d = sin_s[srs_in_alt(route_in.serial_data_in_pin)]; // [RULE3]
    if (clr_in) begin
      // quiet pins while the rest of the chip sits in standby reset
      sck_oe_d = 3'h0;
      sot_oe_d = 3'h0;
      sck_pin_d = 3'h0;
      sot_pin_d = 3'h0;
      sck_rx_d = 1'b0;
      sot_rx_d = 1'b0;
      sin_rx_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= 9'h000;
      sync_q <= 9'h000;
      sck_pin_out <= 3'h0;
      sck_pin_oe_out <= 3'h0;
      sot_pin_out <= 3'h0;
      sot_pin_oe_out <= 3'h0;
      ch_sck_rx_out <= 1'b0;
      ch_sot_rx_out <= 1'b0;
      ch_sin_rx_out <= 1'b0;
    end else begin
      meta_q <= {sin_pin_in, sot_pin_in, sck_pin_in};
      sync_q <= meta_q;
      sck_pin_out <= sck_pin_d;
      sck_pin_oe_out <= sck_oe_d;
      sot_pin_out <= sot_pin_d;
      sot_pin_oe_out <= sot_oe_d;
      ch_sck_rx_out <= sck_rx_d;
      ch_sot_rx_out <= sot_rx_d;
      ch_sin_rx_out <= sin_rx_d;
    end
  end

endmodule : srs_chan_route

// file: srs_route_top.sv
/*
  Serial pin route selector: two route registers on a plain register
  port, five channel routers (ch0, ch4..ch7) and ch4 handshake routing.
  Assumes pins come from outside the clock domain, channel signals and
  the deep standby reset come from logic on ref_clk_in.
*/
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns
`include "srs_defines.svh"
module srs_route_top import srs_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic dstby_rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [4:0][2:0] sck_pin_in,
  output logic [4:0][2:0] sck_pin_out,
  output logic [4:0][2:0] sck_pin_oe_out,
  input wire logic [4:0][2:0] sot_pin_in,
  output logic [4:0][2:0] sot_pin_out,
  output logic [4:0][2:0] sot_pin_oe_out,
  input wire logic [4:0][2:0] sin_pin_in,
  input wire logic [4:0] ch_sck_drv_in,
  input wire logic [4:0] ch_sot_drv_in,
  output logic [4:0] ch_sck_rx_out,
  output logic [4:0] ch_sot_rx_out,
  output logic [4:0] ch_sin_rx_out,
  input wire logic [2:0] cts_pin_in,
  output logic ch4_cts_rx_out,
  input wire logic ch4_rts_drv_in,
  output logic [2:0] rts_pin_out,
  output logic [2:0] rts_pin_oe_out
);

  //////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // route registers

  logic [31:0] ch0_route_q, ch0_route_d;
  logic [31:0] ch47_route_q, ch47_route_d;
  logic [31:0] rdata_d;
  logic wr_ch0, wr_ch47, rd_ch0, rd_ch47;

  assign wr_ch0 = reg_wr_in && (reg_addr_in == `SRS_OFF_CH0_ROUTE);
  assign wr_ch47 = reg_wr_in && (reg_addr_in == `SRS_OFF_CH47_ROUTE);
  assign rd_ch0 = reg_rd_in && (reg_addr_in == `SRS_OFF_CH0_ROUTE);
  assign rd_ch47 = reg_rd_in && (reg_addr_in == `SRS_OFF_CH47_ROUTE);

  always_comb begin
    ch0_route_d = ch0_route_q;
    ch47_route_d = ch47_route_q;
    // reserved groups are not stored, so a careless write cannot leak
    if (wr_ch0) begin
      ch0_route_d = reg_wdata_in & `SRS_CH0_ROUTE_MASK; // [RULE6] [RULE7]
    end
    if (wr_ch47) begin
      ch47_route_d = reg_wdata_in & `SRS_CH47_ROUTE_MASK; // [RULE6] [RULE7]
    end
  end

  // deep standby reset deliberately absent here: routing must survive it
  always_ff @(posedge ref_clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ch0_route_q <= `SRS_CH0_ROUTE_RST; // [RULE4]
      ch47_route_q <= `SRS_CH47_ROUTE_RST; // [RULE4] [RULE8]
    end else begin
      ch0_route_q <= ch0_route_d;
      ch47_route_q <= ch47_route_d; // [RULE18]
    end
  end

  // read data valid for one cycle only; unmapped reads return zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (rd_ch0) begin
      rdata_d = ch0_route_q; // [RULE5]
    end else if (rd_ch47) begin
      rdata_d = ch47_route_q; // [RULE5] [RULE13]
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      reg_rdata_out <= 32'h00000000;
    end else begin
      reg_rdata_out <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // channel routers: index 0 is ch0, indices 1..4 are ch4..ch7

  logic standby_clr;

  assign standby_clr = !dstby_rst_b_in;

  for (genvar g = 0; g < 5; g++) begin : g_ch
    srs_ch_route_t route;

    if (g == 0) begin : g_ch0
      assign route = srs_ch_route_t'(
        ch0_route_q[`SRS_CH0_GRP_LSB +: `SRS_GRP_W]); // [RULE9]
    end else begin : g_ch47
      assign route = srs_ch_route_t'(
        ch47_route_q[`SRS_CH4_GRP_LSB + `SRS_GRP_W * (g - 1)
          +: `SRS_GRP_W]); // [RULE10] [RULE11] [RULE12] [RULE14]
    end

    srs_chan_route u_route (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_sync_q),
      .clr_in(standby_clr),
      .route_in(route),
      .sck_pin_in(sck_pin_in[g]),
      .sck_pin_out(sck_pin_out[g]),
      .sck_pin_oe_out(sck_pin_oe_out[g]),
      .sot_pin_in(sot_pin_in[g]),
      .sot_pin_out(sot_pin_out[g]),
      .sot_pin_oe_out(sot_pin_oe_out[g]),
      .sin_pin_in(sin_pin_in[g]),
      .ch_sck_drv_in(ch_sck_drv_in[g]),
      .ch_sot_drv_in(ch_sot_drv_in[g]),
      .ch_sck_rx_out(ch_sck_rx_out[g]),
      .ch_sot_rx_out(ch_sot_rx_out[g]),
      .ch_sin_rx_out(ch_sin_rx_out[g])
    );
  end

  //////////////////////////////////////////////////////////////////////
  // ch4 handshake routing

  srs_route_t cts_sel, rts_sel;
  logic [2:0] cts_meta_q, cts_sync_q;
  logic cts_rx_d;
  logic [2:0] rts_pin_d, rts_oe_d;

  assign cts_sel = srs_route_t'(ch47_route_q[`SRS_CTS4_LSB +: 2]);
  assign rts_sel = srs_route_t'(ch47_route_q[`SRS_RTS4_LSB +: 2]);

  always_comb begin
    cts_rx_d = cts_sync_q[srs_in_alt(cts_sel)]; // [RULE15] [RULE16]
    rts_oe_d = srs_out_alt(rts_sel); // [RULE17]
    rts_pin_d = {3{ch4_rts_drv_in}};
    if (standby_clr) begin
      cts_rx_d = 1'b0;
      rts_oe_d = 3'h0;
      rts_pin_d = 3'h0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cts_meta_q <= 3'h0;
      cts_sync_q <= 3'h0;
      ch4_cts_rx_out <= 1'b0;
      rts_pin_out <= 3'h0;
      rts_pin_oe_out <= 3'h0;
    end else begin
      cts_meta_q <= cts_pin_in;
      cts_sync_q <= cts_meta_q;
      ch4_cts_rx_out <= cts_rx_d;
      rts_pin_out <= rts_pin_d;
      rts_pin_oe_out <= rts_oe_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_sync_q);

  reset_fields_zero_a : assert property ( // [RULE4]
    $rose(rst_sync_q) |-> ch0_route_q == 32'h00000000
      && ch47_route_q == 32'h00000000 && reg_rdata_out == 32'h00000000)
    else $error("route fields not cleared by reset");

  read_ch0_value_a : assert property ( // [RULE5]
    rd_ch0 && !$past(reg_wr_in) && $stable(dstby_rst_b_in)
      |=> reg_rdata_out == $past(ch0_route_q)
      && $stable(ch0_route_q) && $stable(sck_pin_oe_out))
    else $error("ch0 route read wrong or disturbed routing");

  read_ch47_value_a : assert property ( // [RULE13]
    rd_ch47 |=> reg_rdata_out == $past(ch47_route_q))
    else $error("ch4-7 route read wrong");

  reserved_read_zero_a : assert property ( // [RULE6]
    reg_rdata_out[31:28] == 4'h0
      && (!$past(rd_ch0) || reg_rdata_out[3:0] == 4'h0))
    else $error("reserved route bits read nonzero");

  standby_keeps_a : assert property ( // [RULE8]
    (!dstby_rst_b_in && !reg_wr_in) |=> $stable(ch47_route_q)
      && $stable(ch0_route_q))
    else $error("route contents lost in deep standby reset");

  ch0_clock_alt2_a : assert property ( // [RULE1]
    (wr_ch0 && reg_wdata_in[9:8] == 2'b11) ##1 dstby_rst_b_in[*2]
      |-> sck_pin_oe_out[0] == 3'h4
        && sck_pin_out[0][2] == $past(ch_sck_drv_in[0]))
    else $error("ch0 clock not driven on alternative 2");

  ch0_dout_idle_a : assert property ( // [RULE2]
    (wr_ch0 && reg_wdata_in[7:6] == 2'b00) |-> ##2
      sot_pin_oe_out[0] == 3'h0)
    else $error("ch0 data-out driven while idle");

  ch7_din_alt2_a : assert property ( // [RULE3]
    (ch47_route_q[23:22] == 2'b11 && dstby_rst_b_in)[*4]
      |-> ch_sin_rx_out[4] == $past(sin_pin_in[4][2], 3))
    else $error("ch7 data-in not taken from alternative 2");

  ch7_dout_alt1_a : assert property ( // [RULE10]
    (ch47_route_q[25:24] == 2'b10 && dstby_rst_b_in)[*2]
      |-> sot_pin_oe_out[4] == 3'h2)
    else $error("ch7 data-out not on alternative 1");

  ch6_clock_alt0_a : assert property ( // [RULE11]
    (ch47_route_q[21:20] == 2'b01 && dstby_rst_b_in)[*4]
      |-> sck_pin_oe_out[3] == 3'h1
        && ch_sck_rx_out[3] == $past(sck_pin_in[3][0], 3))
    else $error("ch6 clock not routed both ways on alternative 0");

  ch5_clock_alt1_a : assert property ( // [RULE12]
    (ch47_route_q[15:14] == 2'b10 && dstby_rst_b_in)[*2]
      |-> sck_pin_oe_out[2] == 3'h2)
    else $error("ch5 clock not on alternative 1");

  ch4_clock_write_a : assert property ( // [RULE14]
    (wr_ch47 && reg_wdata_in[9:8] == 2'b01) ##1 dstby_rst_b_in[*2]
      |-> sck_pin_oe_out[1] == 3'h1)
    else $error("ch4 clock field not at bits 9:8");

  ch4_cts_alt0_a : assert property ( // [RULE16]
    (ch47_route_q[3:2] == 2'b01 && dstby_rst_b_in)[*4]
      |-> ch4_cts_rx_out == $past(cts_pin_in[0], 3))
    else $error("ch4 clear-to-send code 01 not on alternative 0");

  ch4_rts_route_a : assert property ( // [RULE17]
    ch47_route_q[1:0] == 2'b00 |=> rts_pin_oe_out == 3'h0)
    else $error("request-to-send driven while idle");

  ch4_din_field_a : assert property ( // [RULE15]
    (wr_ch47 && reg_wdata_in[5:4] == 2'b10) |=>
      ch47_route_q[5:4] == 2'b10 && ch47_route_q[3:2] == $past(
        reg_wdata_in[3:2]))
    else $error("ch4 data-in or clear-to-send field misplaced");

  other_ch_stable_a : assert property ( // [RULE18]
    (wr_ch0 && dstby_rst_b_in) ##1 dstby_rst_b_in
      |-> $stable(ch47_route_q) ##1 $stable(sck_pin_oe_out[4:1]))
    else $error("ch0 write disturbed ch4-7 routing");

  ch0_field_layout_a : assert property ( // [RULE9]
    wr_ch0 |=> ch0_route_q[9:4] == $past(reg_wdata_in[9:4])
      && ch0_route_q[3:0] == 4'h0)
    else $error("ch0 route fields misplaced");

  rdata_idle_zero_a : assert property ( // [RULE5]
    !rd_ch0 && !rd_ch47 |=> reg_rdata_out == 32'h00000000)
    else $error("read data present without a route read");

  route_reserved_zero_a : assert property ( // [RULE6]
    ch0_route_q[31:10] == 22'h000000 && ch0_route_q[3:0] == 4'h0
      && ch47_route_q[31:28] == 4'h0)
    else $error("reserved route bits stored");

  standby_quiet_a : assert property ( // [RULE8]
    !dstby_rst_b_in |=> sck_pin_oe_out == 15'h0000
      && sot_pin_oe_out == 15'h0000 && rts_pin_oe_out == 3'h0)
    else $error("pins driven during deep standby reset");

  write_next_cycle_a : assert property ( // [RULE18]
    wr_ch47 |=> ch47_route_q[27:0] == $past(reg_wdata_in[27:0]))
    else $error("ch4-7 route write not stored next cycle");

  ch7_clock_idle_a : assert property ( // [RULE1]
    (ch47_route_q[27:26] == 2'b00 && dstby_rst_b_in)[*4]
      |-> sck_pin_oe_out[4] == 3'h0
        && ch_sck_rx_out[4] == $past(sck_pin_in[4][0], 3))
    else $error("ch7 clock idle code drives or reads wrong pin");

  ch4_dout_alt0_a : assert property ( // [RULE15]
    (ch47_route_q[7:6] == 2'b01 && dstby_rst_b_in)[*2]
      |-> sot_pin_oe_out[1] == 3'h1)
    else $error("ch4 data-out not on alternative 0");

  ch0_din_alt1_a : assert property ( // [RULE3]
    (ch0_route_q[5:4] == 2'b10 && dstby_rst_b_in)[*4]
      |-> ch_sin_rx_out[0] == $past(sin_pin_in[0][1], 3))
    else $error("ch0 data-in not taken from alternative 1");

  ch6_din_code01_a : assert property ( // [RULE11]
    (ch47_route_q[17:16] == 2'b01 && dstby_rst_b_in)[*4]
      |-> ch_sin_rx_out[3] == $past(sin_pin_in[3][0], 3))
    else $error("ch6 data-in code 01 not on alternative 0");

  ch5_din_alt2_a : assert property ( // [RULE14]
    (ch47_route_q[11:10] == 2'b11 && dstby_rst_b_in)[*4]
      |-> ch_sin_rx_out[2] == $past(sin_pin_in[2][2], 3))
    else $error("ch5 data-in not taken from alternative 2");

  ch4_cts_alt2_a : assert property ( // [RULE16]
    (ch47_route_q[3:2] == 2'b11 && dstby_rst_b_in)[*4]
      |-> ch4_cts_rx_out == $past(cts_pin_in[2], 3))
    else $error("ch4 clear-to-send not on alternative 2");

  ch4_rts_alt1_a : assert property ( // [RULE17]
    (ch47_route_q[1:0] == 2'b10 && dstby_rst_b_in)[*2]
      |-> rts_pin_oe_out == 3'h2 && rts_pin_out[1] == $past(ch4_rts_drv_in))
    else $error("request-to-send not driven on alternative 1");

  cover_ch0_drive_c : cover property (
    wr_ch0 && reg_wdata_in[9:8] == 2'b01 ##2 sck_pin_oe_out[0] == 3'h1);

  cover_ch47_read_c : cover property (
    wr_ch47 ##1 rd_ch47 ##1 reg_rdata_out != 32'h00000000);

  cover_standby_c : cover property (
    ch47_route_q != 32'h00000000 ##1 (!dstby_rst_b_in)[*3]
      ##1 dstby_rst_b_in);

  cover_rts_alt2_c : cover property (rts_pin_oe_out == 3'h4);

  cover_cts_alt2_c : cover property (
    ch47_route_q[3:2] == 2'b11 && ch4_cts_rx_out);

endmodule : srs_route_top

// file: srs_pin_model.sv
/*
  Board-side model of the route selector's two-way clock and data-out
  pins: works out each pin's level from the selector's drive and the
  level that the board puts on it.
  Assumes the bench holds the board levels steady around each check.
*/
`timescale 1ns/1ns
module srs_pin_model (
  input wire logic [4:0][2:0] sck_drv_in,
  input wire logic [4:0][2:0] sck_oe_in,
  input wire logic [4:0][2:0] sck_ext_in,
  input wire logic [4:0][2:0] sot_drv_in,
  input wire logic [4:0][2:0] sot_oe_in,
  input wire logic [4:0][2:0] sot_ext_in,
  output logic [4:0][2:0] sck_wire_out,
  output logic [4:0][2:0] sot_wire_out
);
  ////////////////////////////////////////////////////////////////////////////
  // selector wins where it drives, board level elsewhere
  assign sck_wire_out = (sck_oe_in & sck_drv_in) | (~sck_oe_in & sck_ext_in);
  assign sot_wire_out = (sot_oe_in & sot_drv_in) | (~sot_oe_in & sot_ext_in);
endmodule : srs_pin_model

// file: srs_route_top_test.sv
/*
  Self-checking bench of the serial pin route selector.
  Assumes the design's own assertions run beside it; a board model
  closes the loop on the two-way pins.
*/
`timescale 1ns/1ns
`include "srs_defines.svh"
module srs_route_top_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic dstby_b = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, r0, r47, v;
  logic [4:0][2:0] sck_ext = '0, sot_ext = '0, sin_pin = '0;
  logic [4:0][2:0] sck_w, sot_w, sck_o, sck_oe, sot_o, sot_oe;
  logic [4:0] sck_drv = '0, sot_drv = '0, sck_rx, sot_rx, sin_rx;
  logic [2:0] cts_pin = 3'h0, rts_o, rts_oe;
  logic cts_rx, rd_pend = 1'b0, run = 1'b0, rts_drv = 1'b0;
  logic [15:0] lf = 16'h7bf5;
  logic [31:0] exp_q [$];
  int err_total = 0;
  int checks_done = 0;

  srs_route_top srs_route_top_inst (
    .ref_clk_in(clk), .rst_b_in(rst_b), .dstby_rst_b_in(dstby_b),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata),
    .sck_pin_in(sck_w), .sck_pin_out(sck_o), .sck_pin_oe_out(sck_oe),
    .sot_pin_in(sot_w), .sot_pin_out(sot_o), .sot_pin_oe_out(sot_oe),
    .sin_pin_in(sin_pin), .ch_sck_drv_in(sck_drv), .ch_sot_drv_in(sot_drv),
    .ch_sck_rx_out(sck_rx), .ch_sot_rx_out(sot_rx), .ch_sin_rx_out(sin_rx),
    .cts_pin_in(cts_pin), .ch4_cts_rx_out(cts_rx),
    .ch4_rts_drv_in(rts_drv), .rts_pin_out(rts_o), .rts_pin_oe_out(rts_oe)
  );
  srs_pin_model srs_pin_model_inst (
    .sck_drv_in(sck_o), .sck_oe_in(sck_oe), .sck_ext_in(sck_ext),
    .sot_drv_in(sot_o), .sot_oe_in(sot_oe), .sot_ext_in(sot_ext),
    .sck_wire_out(sck_w), .sot_wire_out(sot_w)
  );

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [2:0] oh(input logic [1:0] c);
    oh = (c == 2'h0) ? 3'h0 : 3'h1 << (c - 2'h1);
  endfunction : oh

  function automatic logic [1:0] ia(input logic [1:0] c);
    ia = (c < 2'h2) ? 2'h0 : c - 2'h1;
  endfunction : ia

  task automatic nxt(output logic [31:0] r);
    repeat (16) lf = lfsr(lf);
    r[15:0] = lf;
    repeat (16) lf = lfsr(lf);
    r[31:16] = lf;
  endtask : nxt

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // strobes stay up between calls so back-to-back cycles need no gap
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= 1'b0;
    wr <= 1'b1;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
  endtask : rd_reg

  task automatic idle(input int n);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic rd_both();
    rd_reg(`SRS_OFF_CH0_ROUTE, r0);
    rd_reg(`SRS_OFF_CH47_ROUTE, r47);
    idle(6);
  endtask : rd_both

  task automatic chk_pins(input bit full);
    logic [5:0] g;
    for (int i = 0; i < 5; i++) begin
      g = (i == 0) ? r0[9:4] : r47[6*i-2 +: 6];
      chk("sck_oe", 32'(sck_oe[i]), 32'(oh(g[5:4])));
      chk("sot_oe", 32'(sot_oe[i]), 32'(oh(g[3:2])));
      if (full) begin
        chk("sck_out", 32'(sck_o[i]), 32'({3{sck_drv[i]}}));
        chk("sot_out", 32'(sot_o[i]), 32'({3{sot_drv[i]}}));
        chk("sck_rx", 32'(sck_rx[i]),
            32'((g[5:4] == 2'h0) ? sck_ext[i][0] : sck_drv[i]));
        chk("sot_rx", 32'(sot_rx[i]),
            32'((g[3:2] == 2'h0) ? sot_ext[i][0] : sot_drv[i]));
        chk("sin_rx", 32'(sin_rx[i]),
            32'(sin_pin[i][ia(g[1:0])]));
      end
    end
    chk("rts_oe", 32'(rts_oe), 32'(oh(r47[1:0])));
    if (full) begin
      chk("rts_out", 32'(rts_o & rts_oe),
          32'(oh(r47[1:0]) & {3{rts_drv}}));
      chk("cts_rx", 32'(cts_rx), 32'(cts_pin[ia(r47[3:2])]));
    end
  endtask : chk_pins

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (run) begin
      if (rd_pend) begin
        chk("rdata", rdata, exp_q.pop_front());
      end else begin
        chk("rdata_idle", rdata, 32'h0);
      end
    end
    rd_pend <= rd;
  end

  initial begin
    #500000;
    err_total++;
    conclude();
  end

  initial begin
    r0 = 32'h0;
    r47 = 32'h0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    run <= 1'b1;
    idle(0);
    chk_pins(1);
    rd_both();
    // ones into reserved groups and an unmapped place
    wr_reg(`SRS_OFF_CH0_ROUTE, 32'hffffffff);
    wr_reg(`SRS_OFF_CH47_ROUTE, 32'hffffffff);
    wr_reg(8'h08, 32'hffffffff);
    rd_reg(8'h08, 32'h0);
    r0 = 32'h000003f0;
    r47 = 32'h0fffffff;
    rd_both();
    chk_pins(1);
    for (int n = 0; n < 12; n++) begin
      @(posedge clk);
      nxt(v);
      sck_ext <= v[14:0];
      sot_ext <= v[29:15];
      rts_drv <= v[30];
      nxt(v);
      sin_pin <= v[14:0];
      cts_pin <= v[17:15];
      sck_drv <= v[22:18];
      sot_drv <= v[27:23];
      nxt(v);
      r47 = v & 32'h0fffffff;
      nxt(v);
      r0 = v & 32'h000003f0;
      wr_reg(`SRS_OFF_CH0_ROUTE, r0);
      wr_reg(`SRS_OFF_CH47_ROUTE, r47);
      idle(1);
      chk_pins(0);
      rd_both();
      chk_pins(1);
    end
    @(posedge clk);
    dstby_b <= 1'b0;
    idle(3);
    chk("dstby_oe", 32'(sck_oe | sot_oe), 32'h0);
    chk("dstby_rts", 32'(rts_oe), 32'h0);
    @(posedge clk);
    dstby_b <= 1'b1;
    idle(6);
    chk_pins(1);
    rd_both();
    @(posedge clk);
    run <= 1'b0;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    run <= 1'b1;
    r0 = 32'h0;
    r47 = 32'h0;
    idle(6);
    chk_pins(1);
    rd_both();
    conclude();
  end
endmodule : srs_route_top_test
